// ### rtl/fic_params.svh
// fic_params.svh: constants of the fault indication and cause store
// assumes a 20 MHz clock; included by bare name
`ifndef FIC_PARAMS_SVH
`define FIC_PARAMS_SVH

`define FIC_CLK_HZ 20000000
`define FIC_BLINK_HALF_MS 250
`define FIC_BLINK_HALF_CYC ((`FIC_CLK_HZ / 1000) * `FIC_BLINK_HALF_MS)
`define FIC_CAUSE_BYTES 16
`define FIC_RUN_BYTES 6
`define FIC_RESET_BYTE 8'h00
`define FIC_CODE_W 7

`endif

// ### rtl/fic_pkg.sv
// fic_pkg.sv: types of the fault indication and cause store
// assumes nothing of its surroundings
package fic_pkg;
    typedef enum logic [1:0] {
        FIC_STARTUP = 2'b00,
        FIC_RUN = 2'b01,
        FIC_STOP = 2'b11
    } fic_mode_t;

    typedef enum logic [1:0] {
        FIC_STOP_NONE = 2'b00,
        FIC_STOP_MALF = 2'b01,
        FIC_STOP_LOAD = 2'b10
    } fic_stop_t;
endpackage

// ### rtl/fic_sync.sv
// fic_sync.sv: two flip-flop synchroniser for a bus of levels
// assumes inputs arrive from outside the clock domain
`timescale 1ns/10ps
module fic_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
        end
    end

    assign q_o = s2_reg;
endmodule // fic_sync

// ### rtl/fic_top.sv
// fic_top.sv: panel lamp driver and fault cause memory with byte readout
// assumes operating state and fault events come from the processor core on
// clk_i; readout requests come from the diagnostic port pins
`timescale 1ns/10ps
`include "fic_params.svh"
module fic_top #(
    parameter int CAUSE_BYTES = `FIC_CAUSE_BYTES,
    parameter int RUN_BYTES = `FIC_RUN_BYTES,
    parameter int BLINK_HALF_CYC = `FIC_BLINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire fic_pkg::fic_mode_t mode_i,
    input wire fic_pkg::fic_stop_t stop_cause_i,
    input wire logic fault_set_i,
    input wire logic [`FIC_CODE_W-1:0] fault_code_i,
    input wire logic rd_req_i,
    input wire logic [3:0] rd_addr_i,
    output logic red_lamp_o,
    output logic green_lamp_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_refused_o
);
    // ************************************************************
    // diagnostic port synchronisation
    // ************************************************************
    logic rd_req_s;
    logic [3:0] rd_addr_s;
    logic rd_req_d_reg;
    logic rd_req_d_next;
    logic rd_stb;

    fic_sync #(.W(5)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i({rd_req_i, rd_addr_i}),
        .q_o({rd_req_s, rd_addr_s})
    );

    always_comb begin
        rd_req_d_next = rd_req_s;
    end
    assign rd_stb = rd_req_s & ~rd_req_d_reg;

    // ************************************************************
    // fault cause memory
    // ************************************************************
    logic [7:0] mem_reg [CAUSE_BYTES];
    logic [7:0] mem_next [CAUSE_BYTES];
    logic [3:0] set_byte;
    logic [2:0] set_bit;

    assign set_byte = fault_code_i[6:3];
    assign set_bit = fault_code_i[2:0];

    always_comb begin
        for (int i = 0; i < CAUSE_BYTES; i++) begin
            mem_next[i] = mem_reg[i];
            if (fault_set_i && (int'(set_byte) == i)) begin
                mem_next[i][set_bit] = 1'b1;
            end
        end
    end

    // ************************************************************
    // readout
    // ************************************************************
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic rd_refused_reg;
    logic rd_refused_next;
    logic rd_allowed;

    // running: control bytes only; stopped: whole area; start-up: none
    always_comb begin
        rd_allowed = 1'b0;
        if (int'(rd_addr_s) < CAUSE_BYTES) begin
            case (mode_i)
                fic_pkg::FIC_STOP: rd_allowed = 1'b1;
                fic_pkg::FIC_RUN: rd_allowed = int'(rd_addr_s) < RUN_BYTES;
                default: rd_allowed = 1'b0;
            endcase
        end
    end

    always_comb begin
        rd_data_next = rd_data_reg;
        rd_valid_next = 1'b0;
        rd_refused_next = 1'b0;
        if (rd_stb) begin
            if (rd_allowed) begin
                rd_data_next = mem_reg[rd_addr_s];
                rd_valid_next = 1'b1;
            end else begin
                rd_data_next = `FIC_RESET_BYTE;
                rd_refused_next = 1'b1;
            end
        end
    end

    // ************************************************************
    // panel lamps
    // ************************************************************
    logic [31:0] blink_cnt_reg;
    logic [31:0] blink_cnt_next;
    logic blink_reg;
    logic blink_next;
    logic red_reg;
    logic red_next;
    logic green_reg;
    logic green_next;

    always_comb begin
        blink_cnt_next = blink_cnt_reg + 32'h0000_0001;
        blink_next = blink_reg;
        if (int'(blink_cnt_reg) >= BLINK_HALF_CYC - 1) begin
            blink_cnt_next = 32'h0000_0000;
            blink_next = ~blink_reg;
        end
    end

    always_comb begin
        red_next = 1'b0;
        green_next = 1'b0;
        case (mode_i)
            fic_pkg::FIC_STARTUP: begin
                red_next = 1'b1;
                green_next = 1'b1;
            end
            fic_pkg::FIC_RUN: begin
                green_next = 1'b1;
            end
            fic_pkg::FIC_STOP: begin
                // load failure wins: its blink tells the operator more
                if (stop_cause_i == fic_pkg::FIC_STOP_LOAD) begin
                    red_next = blink_next;
                end else if (stop_cause_i == fic_pkg::FIC_STOP_MALF) begin
                    red_next = 1'b1;
                end
            end
            default: begin
                red_next = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < CAUSE_BYTES; i++) begin
                mem_reg[i] <= `FIC_RESET_BYTE;
            end
            rd_req_d_reg <= 1'b0;
            rd_data_reg <= `FIC_RESET_BYTE;
            rd_valid_reg <= 1'b0;
            rd_refused_reg <= 1'b0;
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
            red_reg <= 1'b0;
            green_reg <= 1'b0;
        end else begin
            mem_reg <= mem_next;
            rd_req_d_reg <= rd_req_d_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            rd_refused_reg <= rd_refused_next;
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            red_reg <= red_next;
            green_reg <= green_next;
        end
    end

    assign red_lamp_o = red_reg;
    assign green_lamp_o = green_reg;
    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign rd_refused_o = rd_refused_reg;

    // ************************************************************
    // checks
    // ************************************************************
    property p_malf_red;
        @(posedge clk_i) disable iff (srst_i)
        (mode_i == fic_pkg::FIC_STOP && stop_cause_i == fic_pkg::FIC_STOP_MALF)
            |=> red_lamp_o && !green_lamp_o;
    endproperty
    a_malf_red: assert property (p_malf_red) else $error("red not steady");

    property p_load_blink;
        @(posedge clk_i) disable iff (srst_i)
        (mode_i == fic_pkg::FIC_STOP && stop_cause_i == fic_pkg::FIC_STOP_LOAD)
            |=> red_lamp_o == blink_reg;
    endproperty
    a_load_blink: assert property (p_load_blink) else $error("red not blinking");

    property p_run_green;
        @(posedge clk_i) disable iff (srst_i)
        mode_i == fic_pkg::FIC_RUN |=> green_lamp_o && !red_lamp_o;
    endproperty
    a_run_green: assert property (p_run_green) else $error("green not lit");

    property p_start_both;
        @(posedge clk_i) disable iff (srst_i)
        mode_i == fic_pkg::FIC_STARTUP |=> red_lamp_o && green_lamp_o;
    endproperty
    a_start_both: assert property (p_start_both) else $error("lamps not both on");

    property p_set_bit;
        @(posedge clk_i) disable iff (srst_i)
        fault_set_i |=> mem_reg[$past(set_byte)][$past(set_bit)];
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("cause bit not set");

    property p_read_data;
        @(posedge clk_i) disable iff (srst_i)
        rd_stb && rd_allowed |=> rd_valid_o && rd_data_o == $past(mem_reg[rd_addr_s]);
    endproperty
    a_read_data: assert property (p_read_data) else $error("wrong readout byte");

    property p_run_limit;
        @(posedge clk_i) disable iff (srst_i)
        rd_stb && mode_i == fic_pkg::FIC_RUN && rd_addr_s >= 4'(RUN_BYTES)
            |=> rd_refused_o && !rd_valid_o;
    endproperty
    a_run_limit: assert property (p_run_limit) else $error("run readout not limited");

    // whole area flattened so that no cause bit anywhere may drop
    logic [8*CAUSE_BYTES-1:0] mem_flat;

    always_comb begin
        for (int i = 0; i < CAUSE_BYTES; i++) begin
            mem_flat[8*i +: 8] = mem_reg[i];
        end
    end

    property p_sticky;
        @(posedge clk_i) disable iff (srst_i)
        mem_flat != '0 |=> (mem_flat & $past(mem_flat)) == $past(mem_flat);
    endproperty
    a_sticky: assert property (p_sticky) else $error("cause bit lost");
endmodule // fic_top

// ### verification/fic_prog_unit.sv
// fic_prog_unit.sv: model of the programming unit on the diagnostic read port
// assumes the bench calls read() from one process only
`timescale 1ns/10ps
module fic_prog_unit (
    input wire logic clk_i,
    output logic rd_req_o,
    output logic [3:0] rd_addr_o
);
    initial begin
        rd_req_o = 1'b0;
        rd_addr_o = 4'h0;
    end

    // one byte per request, held long enough for the synchroniser
    // full readout is asked for both while running and while stopped
    task automatic read(input logic [3:0] a);
        // index settles a cycle ahead of the request, so the sync sees both together
        @(posedge clk_i);
        #1 rd_addr_o = a;
        @(posedge clk_i);
        #1 rd_req_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 rd_req_o = 1'b0;
        // released lines must not keep showing the last index
        rd_addr_o = ~a;
        repeat (3) @(posedge clk_i);
    endtask
endmodule // fic_prog_unit

// ### verification/tb_fault_indication_and_cause_store.sv
// tb_fault_indication_and_cause_store.sv: self-checking bench for fic_top
// assumes fic_top with a shortened blink half period of 4 cycles
`timescale 1ns/10ps
module tb_fault_indication_and_cause_store;
    logic clk_i, srst_i, fault_set_i, rd_req_i, prev;
    fic_pkg::fic_mode_t mode_i;
    fic_pkg::fic_stop_t stop_cause_i;
    logic [6:0] fault_code_i;
    logic [3:0] rd_addr_i;
    logic red_lamp_o, green_lamp_o, rd_valid_o, rd_refused_o;
    logic [7:0] rd_data_o;
    logic [7:0] mem [16];
    logic [8:0] exp_q [$];
    int err_count = 0;
    int check_count = 0;
    int seed = 32'h1ab4_8915;
    int n;

    fic_top #(.BLINK_HALF_CYC(4)) fic_top_inst (.clk_i(clk_i), .srst_i(srst_i),
        .mode_i(mode_i), .stop_cause_i(stop_cause_i), .fault_set_i(fault_set_i),
        .fault_code_i(fault_code_i), .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i),
        .red_lamp_o(red_lamp_o), .green_lamp_o(green_lamp_o), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .rd_refused_o(rd_refused_o));
    fic_prog_unit fic_prog_unit_inst (.clk_i(clk_i), .rd_req_o(rd_req_i),
        .rd_addr_o(rd_addr_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic cmp(input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmp_lamp(input logic [1:0] e);
        cmp({7'h00, e}, {7'h00, red_lamp_o, green_lamp_o});
    endtask

    // ****************************************************************
    // readout scoreboard: expected {refused, data} queued by the driver
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rd_valid_o === 1'b1 || rd_refused_o === 1'b1) begin
            cmp(exp_q.size() ? exp_q.pop_front() : 9'h1ff, {rd_refused_o, rd_data_o});
        end
    end

    task automatic rd(input logic [3:0] a, input logic ok);
        exp_q.push_back(ok ? {1'b0, mem[a]} : 9'h100);
        fic_prog_unit_inst.read(a);
        // a request that got no answer within the model's slot
        if (exp_q.size() != 0) cmp(exp_q.pop_front(), 9'h1ff);
    endtask

    task automatic lamps(input fic_pkg::fic_mode_t m, input fic_pkg::fic_stop_t s,
                         input logic [1:0] e);
        @(posedge clk_i);
        #1 mode_i = m;
        stop_cause_i = s;
        repeat (3) @(posedge clk_i);
        #1 cmp_lamp(e);
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        mode_i = fic_pkg::FIC_STARTUP;
        stop_cause_i = fic_pkg::FIC_STOP_NONE;
        fault_set_i = 1'b0;
        fault_code_i = 7'h00;
        srst_i = 1'b1;
        for (int i = 0; i < 16; i++) mem[i] = 8'h00;
        repeat (2) @(posedge clk_i);
        #1 srst_i = 1'b0;
        lamps(fic_pkg::FIC_STARTUP, fic_pkg::FIC_STOP_NONE, 2'b11);
        rd(4'h0, 1'b0);
        $display("startup test done");
        lamps(fic_pkg::FIC_RUN, fic_pkg::FIC_STOP_NONE, 2'b01);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            #1 fault_set_i = 1'b1;
            fault_code_i = 7'($random(seed));
            mem[fault_code_i[6:3]][fault_code_i[2:0]] = 1'b1;
        end
        @(posedge clk_i);
        #1 fault_set_i = 1'b0;
        cmp_lamp(2'b01);
        for (int i = 0; i < 16; i++) rd(i[3:0], i < 6);
        $display("run test done");
        lamps(fic_pkg::FIC_STOP, fic_pkg::FIC_STOP_MALF, 2'b10);
        repeat (12) begin
            @(posedge clk_i);
            #1 cmp_lamp(2'b10);
        end
        for (int i = 0; i < 16; i++) rd(i[3:0], 1'b1);
        $display("malfunction stop test done");
        lamps(fic_pkg::FIC_STOP, fic_pkg::FIC_STOP_NONE, 2'b00);
        @(posedge clk_i);
        #1 stop_cause_i = fic_pkg::FIC_STOP_LOAD;
        repeat (3) @(posedge clk_i);
        // blink phase runs free, so only the green lamp has a fixed value here
        #1 cmp(9'h000, {8'h00, green_lamp_o});
        prev = red_lamp_o;
        n = 0;
        // 16 intervals at a 4-cycle half period give exactly 4 toggles
        repeat (16) begin
            @(posedge clk_i);
            #1 if (red_lamp_o !== prev) n++;
            prev = red_lamp_o;
        end
        cmp(9'h004, 9'(n));
        $display("load failure blink test done");
        srst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 srst_i = 1'b0;
        for (int i = 0; i < 16; i++) mem[i] = 8'h00;
        lamps(fic_pkg::FIC_STOP, fic_pkg::FIC_STOP_MALF, 2'b10);
        rd(4'h3, 1'b1);
        $display("second reset test done");
        summarize();
    end
endmodule // tb_fault_indication_and_cause_store
